// [hdl/phy_diag_pkg.sv]
package phy_diag_pkg;

  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned BLINK_HALF_MS = 40;
  localparam int unsigned BLINK_CYCLES = (BLINK_HALF_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned QUALITY_US = 2;
  localparam int unsigned QUALITY_CYCLES = (QUALITY_US * 1000) / CLK_PERIOD_NS;

  // ----------------------------------------
  // register indices (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [9:0] IDX_BASIC = 10'h000;
  localparam logic [9:0] IDX_PULSE_SEL = 10'h013;
  localparam logic [9:0] IDX_INT = 10'h01B;
  localparam logic [9:0] IDX_CTRL1C = 10'h01C;
  localparam logic [9:0] IDX_CABLE = 10'h01D;
  localparam logic [9:0] IDX_CTRL2 = 10'h01F;
  localparam logic [9:0] IDX_AMP = 10'h02D;
  localparam logic [9:0] IDX_QUALITY = 10'h0AC;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int unsigned BC_LOOP = 14;
  localparam int unsigned BC_SPEED = 13;
  localparam int unsigned BC_ANEG = 12;
  localparam int unsigned BC_DUPLEX = 8;
  localparam int unsigned C1C_LOCAL = 5;
  localparam int unsigned C2_SWAP = 14;
  localparam int unsigned C2_AUTO = 13;
  localparam int unsigned C2_IRQ_POL = 9;
  localparam int unsigned C2_LED_LO = 4;
  localparam int unsigned C2_REMOTE = 2;
  localparam int unsigned CT_START = 15;
  localparam int unsigned CT_RES_LO = 12;
  localparam int unsigned PS_LARGE = 15;
  localparam int unsigned AMP_LO = 4;
  localparam int unsigned Q_LO = 8;

  // ----------------------------------------
  // reset values and strap decode
  // ----------------------------------------
  localparam logic [15:0] BASIC_RST = 16'h3100;
  localparam logic [15:0] CTRL1C_RST = 16'h0000;
  localparam logic [15:0] CTRL2_RST = 16'h0000;
  localparam logic [3:0] AMP_RST = 4'h2;
  localparam logic [2:0] STRAP_AUTO_OFF = 3'h2;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    LED_MAP_DEFAULT = 2'b00,
    LED_MAP_STATUS_ACT = 2'b01
  } led_map_e;

  typedef enum logic {
    CT_IDLE = 1'b0,
    CT_RUN = 1'b1
  } cable_state_e;

  // one di-bit lane: enable plus two data bits
  typedef struct packed {
    logic en;
    logic [1:0] d;
  } dibit_s;

  typedef struct packed {
    logic [2:0] strap_meta;
    logic [2:0] strap_sync;
    logic [1:0] strap_cnt;
    logic strap_done;
    logic wait_req;
    logic [31:0] rdata;
    logic [15:0] basic;
    logic pulse_large;
    logic [7:0] int_en;
    logic [7:0] int_stat;
    logic [15:0] ctrl1c;
    logic [15:0] ctrl2;
    logic [3:0] amp;
    cable_state_e ct_state;
    logic ct_start;
    logic [2:0] ct_result;
    logic [6:0] quality;
    logic [31:0] qcnt;
    logic [31:0] bcnt;
    logic blink_phase;
    logic act_seen;
    logic act_recent;
    logic led_a_n;
    logic led_b_n;
    logic irq;
    logic mdix_swap;
    dibit_s rmii_rx;
    dibit_s line_tx;
  } state_s;

endpackage

// [hdl/phy_status_diag_control.sv]
// Function
// [R1] indicator outputs are active low: lit means pin low.
// [R2] default a=link/activity, b=speed; control-2 [5:4] selects link status/activity.
// [R3] link/activity: on with idle link, blinks with traffic.
// [R4] activity: blinks with traffic, off otherwise.
// [R5] speed: on for 100 Mbps link, off for 10 Mbps.
// [R6] link status: on while link up.
// [R7] interrupt register upper byte enables conditions onto the output.
// [R8] interrupt register lower byte holds sticky condition flags.
// [R9] reading the interrupt register clears its flags.
// [R10] control-2 bit 9 sets interrupt polarity, reset gives active low.
// [R11] crossover auto enable taken from three straps at reset.
// [R12] control-2 bit 13 later enables or disables auto crossover.
// [R13] manual crossover: normal pairs, control-2 bit 14 swaps them.
// [R14] auto crossover follows the pairs sensed from the partner.
// [R15] local loopback returns RMII transmit to RMII receive.
// [R16] controller sets basic control and bit 5 of 1Ch for local loopback.
// [R17] remote loopback returns line receive to line, only 100 full duplex.
// [R18] controller links at 100 full duplex, then sets control-2 bit 2.
// [R19] cable test starts on bit 15 write with auto crossover off.
// [R20] cable test bit 15 reads one while running, result in 14:12.
// [R21] controller runs small pulse then large pulse passes.
// [R22] controller combines the two pass results.
// [R23] seven-bit receive quality readable, refreshed every 2 us.
// [R24] activity blink uses a fixed visible period from the clock.
//
// The address map and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module phy_status_diag_control #(
  parameter int unsigned BLINK_CYCLES = phy_diag_pkg::BLINK_CYCLES
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // avalon-mm slave
  input wire logic [11:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // straps from pins
  input wire logic [2:0] cfg_strap_i,
  // status from transceiver core
  input wire logic link_up_i,
  input wire logic speed100_i,
  input wire logic full_duplex_i,
  input wire logic activity_i,
  input wire logic partner_swap_i,
  input wire logic [7:0] irq_event_i,
  input wire logic [6:0] quality_raw_i,
  input wire logic tdr_done_i,
  input wire logic [2:0] tdr_result_i,
  // data lanes
  input wire phy_diag_pkg::dibit_s rmii_tx_i,
  input wire phy_diag_pkg::dibit_s core_rx_i,
  input wire phy_diag_pkg::dibit_s line_rx_i,
  output phy_diag_pkg::dibit_s rmii_rx_o,
  output phy_diag_pkg::dibit_s line_tx_o,
  // indicators and interrupt
  output logic indicator_out_a_n_o,
  output logic indicator_out_b_n_o,
  output logic irq_out_o,
  // crossover and cable test control
  output logic mdix_swap_o,
  output logic tdr_start_o,
  output logic tdr_large_o,
  output logic [3:0] tdr_amp_o
);

  phy_diag_pkg::state_s s_q;
  phy_diag_pkg::state_s s_d;

  function automatic logic hit(input logic [11:0] addr, input logic [9:0] idx);
    hit = (addr[11:2] == idx) && (addr[1:0] == 2'h0);
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [15:0] rv;
    logic accept;
    logic auto_on;
    logic act_on;
    logic led_la;
    logic led_act;
    logic led_spd;
    logic led_lnk;
    logic irq_active;
    logic local_en;
    logic remote_en;
    logic [7:0] stat;
    rv = 16'h0000;
    accept = 1'b0;
    auto_on = 1'b0;
    act_on = 1'b0;
    led_la = 1'b0;
    led_act = 1'b0;
    led_spd = 1'b0;
    led_lnk = 1'b0;
    irq_active = 1'b0;
    local_en = 1'b0;
    remote_en = 1'b0;
    stat = 8'h00;
    s_d = s_q;

    // strap synchroniser and capture after release
    s_d.strap_meta = cfg_strap_i;
    s_d.strap_sync = s_q.strap_meta;
    if (!s_q.strap_done) begin
      s_d.strap_cnt = s_q.strap_cnt + 2'h1;
      if (s_q.strap_cnt == 2'h3) begin
        s_d.strap_done = 1'b1;
        // [R11] strap sets auto crossover
        s_d.ctrl2[phy_diag_pkg::C2_AUTO] = (s_q.strap_sync != phy_diag_pkg::STRAP_AUTO_OFF);
      end
    end

    // read mux
    if (hit(avs_address_i, phy_diag_pkg::IDX_BASIC)) begin
      rv = s_q.basic;
    end else if (hit(avs_address_i, phy_diag_pkg::IDX_PULSE_SEL)) begin
      rv = {s_q.pulse_large, 15'h0000};
    end else if (hit(avs_address_i, phy_diag_pkg::IDX_INT)) begin
      rv = {s_q.int_en, s_q.int_stat};
    end else if (hit(avs_address_i, phy_diag_pkg::IDX_CTRL1C)) begin
      rv = s_q.ctrl1c;
    end else if (hit(avs_address_i, phy_diag_pkg::IDX_CABLE)) begin
      // [R20] busy bit and fault result
      rv = {s_q.ct_state == phy_diag_pkg::CT_RUN, s_q.ct_result, 12'h000};
    end else if (hit(avs_address_i, phy_diag_pkg::IDX_CTRL2)) begin
      rv = s_q.ctrl2;
    end else if (hit(avs_address_i, phy_diag_pkg::IDX_AMP)) begin
      rv = {8'h00, s_q.amp, 4'h0};
    end else if (hit(avs_address_i, phy_diag_pkg::IDX_QUALITY)) begin
      // [R23] raw quality readable any time
      rv = {1'b0, s_q.quality, 8'h00};
    end

    // bus handshake: one wait cycle, then accept
    s_d.wait_req = 1'b1;
    if ((avs_read_i || avs_write_i) && s_q.wait_req) begin
      s_d.wait_req = 1'b0;
      s_d.rdata = {16'h0000, rv};
    end
    accept = (avs_read_i || avs_write_i) && !s_q.wait_req;

    // [R8] sticky flags, event wins over clear
    stat = s_q.int_stat;
    // [R9] read clears returned flags
    if (accept && avs_read_i && hit(avs_address_i, phy_diag_pkg::IDX_INT)) begin
      stat = stat & ~s_q.rdata[7:0];
    end
    s_d.int_stat = stat | irq_event_i;

    // cable test sequencing
    s_d.ct_start = 1'b0;
    if (s_q.ct_state == phy_diag_pkg::CT_RUN && tdr_done_i) begin
      s_d.ct_state = phy_diag_pkg::CT_IDLE;
      s_d.ct_result = tdr_result_i;
    end

    // register writes
    if (accept && avs_write_i) begin
      if (hit(avs_address_i, phy_diag_pkg::IDX_BASIC)) begin
        s_d.basic = merge(s_q.basic, avs_writedata_i, avs_byteenable_i);
      end else if (hit(avs_address_i, phy_diag_pkg::IDX_PULSE_SEL)) begin
        if (avs_byteenable_i[1]) begin
          s_d.pulse_large = avs_writedata_i[phy_diag_pkg::PS_LARGE];
        end
      end else if (hit(avs_address_i, phy_diag_pkg::IDX_INT)) begin
        if (avs_byteenable_i[1]) begin
          // [R7] enable byte
          s_d.int_en = avs_writedata_i[15:8];
        end
      end else if (hit(avs_address_i, phy_diag_pkg::IDX_CTRL1C)) begin
        s_d.ctrl1c = merge(s_q.ctrl1c, avs_writedata_i, avs_byteenable_i);
      end else if (hit(avs_address_i, phy_diag_pkg::IDX_CABLE)) begin
        // [R19] start only when idle with auto crossover off
        if (avs_byteenable_i[1] && avs_writedata_i[phy_diag_pkg::CT_START]
            && s_q.ct_state == phy_diag_pkg::CT_IDLE && !s_q.ctrl2[phy_diag_pkg::C2_AUTO]) begin
          s_d.ct_state = phy_diag_pkg::CT_RUN;
          s_d.ct_start = 1'b1;
        end
      end else if (hit(avs_address_i, phy_diag_pkg::IDX_CTRL2)) begin
        // [R12] software overrides strapped auto enable
        s_d.ctrl2 = merge(s_q.ctrl2, avs_writedata_i, avs_byteenable_i);
      end else if (hit(avs_address_i, phy_diag_pkg::IDX_AMP)) begin
        if (avs_byteenable_i[0]) begin
          s_d.amp = avs_writedata_i[phy_diag_pkg::AMP_LO +: 4];
        end
      end
    end

    // [R23] quality sampled every 2 us, no hysteresis
    if (s_q.qcnt >= phy_diag_pkg::QUALITY_CYCLES - 1) begin
      s_d.qcnt = 32'h0000_0000;
      s_d.quality = quality_raw_i;
    end else begin
      s_d.qcnt = s_q.qcnt + 32'h0000_0001;
    end

    // [R24] fixed blink period, activity caught per full blink cycle
    s_d.act_seen = s_q.act_seen | activity_i;
    if (s_q.bcnt >= BLINK_CYCLES - 1) begin
      s_d.bcnt = 32'h0000_0000;
      s_d.blink_phase = !s_q.blink_phase;
      // window opens on the lit half, so every blink shows both halves
      if (!s_q.blink_phase) begin
        s_d.act_recent = s_q.act_seen | activity_i;
        s_d.act_seen = 1'b0;
      end
    end else begin
      s_d.bcnt = s_q.bcnt + 32'h0000_0001;
    end
    act_on = s_q.act_recent && s_q.blink_phase;

    // [R3] link/activity: steady on, dark while blink_phase is low after activity
    led_la = link_up_i && !(s_q.act_recent && !s_q.blink_phase);
    // [R4] activity blinks only with traffic
    led_act = act_on;
    // [R5] speed lit at 100 Mbps
    led_spd = link_up_i && speed100_i;
    // [R6] link status
    led_lnk = link_up_i;

    // [R2] indicator mapping
    // [R1] drive low to light
    case (s_q.ctrl2[phy_diag_pkg::C2_LED_LO +: 2])
      phy_diag_pkg::LED_MAP_STATUS_ACT: begin
        s_d.led_a_n = !led_lnk;
        s_d.led_b_n = !led_act;
      end
      default: begin
        s_d.led_a_n = !led_la;
        s_d.led_b_n = !led_spd;
      end
    endcase

    // [R7] only enabled flags raise the output
    irq_active = |(s_q.int_en & s_q.int_stat);
    // [R10] polarity select, zero means active low
    s_d.irq = s_q.ctrl2[phy_diag_pkg::C2_IRQ_POL] ? irq_active : !irq_active;

    // [R14] auto follows sensed partner pairs
    // [R13] manual keeps or swaps pairs
    auto_on = s_q.ctrl2[phy_diag_pkg::C2_AUTO];
    s_d.mdix_swap = auto_on ? partner_swap_i : s_q.ctrl2[phy_diag_pkg::C2_SWAP];

    // [R15] local loopback needs loop, no aneg, full duplex, enable bit
    local_en = s_q.basic[phy_diag_pkg::BC_LOOP] && !s_q.basic[phy_diag_pkg::BC_ANEG]
               && s_q.basic[phy_diag_pkg::BC_DUPLEX] && s_q.ctrl1c[phy_diag_pkg::C1C_LOCAL];
    // [R17] remote loopback only at 100 full duplex with link
    remote_en = s_q.ctrl2[phy_diag_pkg::C2_REMOTE] && link_up_i && speed100_i
                && full_duplex_i;
    s_d.rmii_rx = local_en ? rmii_tx_i : core_rx_i;
    if (local_en) begin
      s_d.line_tx = '0;
    end else if (remote_en) begin
      s_d.line_tx = line_rx_i;
    end else begin
      s_d.line_tx = rmii_tx_i;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
      s_q.wait_req <= 1'b1;
      s_q.basic <= phy_diag_pkg::BASIC_RST;
      s_q.ctrl1c <= phy_diag_pkg::CTRL1C_RST;
      s_q.ctrl2 <= phy_diag_pkg::CTRL2_RST;
      s_q.amp <= phy_diag_pkg::AMP_RST;
      s_q.ct_state <= phy_diag_pkg::CT_IDLE;
      s_q.led_a_n <= 1'b1;
      s_q.led_b_n <= 1'b1;
      s_q.irq <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign avs_readdata_o = s_q.rdata;
  assign avs_waitrequest_o = s_q.wait_req;
  assign indicator_out_a_n_o = s_q.led_a_n;
  assign indicator_out_b_n_o = s_q.led_b_n;
  assign irq_out_o = s_q.irq;
  assign mdix_swap_o = s_q.mdix_swap;
  assign tdr_start_o = s_q.ct_start;
  assign tdr_large_o = s_q.pulse_large;
  assign tdr_amp_o = s_q.amp;
  assign rmii_rx_o = s_q.rmii_rx;
  assign line_tx_o = s_q.line_tx;

endmodule

`default_nettype wire

// [verification/mgmt_master.sv]
`timescale 1ns/1ns
`default_nettype none

module mgmt_master (
  // clock
  input wire logic mclk_i,
  // avalon-mm master side
  output logic [11:0] address_o,
  output logic read_o,
  output logic write_o,
  output logic [31:0] writedata_o,
  output logic [3:0] byteenable_o,
  input wire logic [31:0] readdata_i,
  input wire logic waitrequest_i
);
  initial begin
    address_o = 12'h000;
    read_o = 1'b0;
    write_o = 1'b0;
    writedata_o = 32'h0000_0000;
    byteenable_o = 4'hF;
  end

  // one whole transfer; idle lines are scrambled after release
  task automatic xfer(input logic w, input logic [9:0] idx, input logic [15:0] wd,
                      output logic [31:0] rdata);
    @(posedge mclk_i);
    address_o <= {idx, 2'b00};
    writedata_o <= {16'h0000, wd};
    write_o <= w;
    read_o <= !w;
    do @(posedge mclk_i); while (waitrequest_i !== 1'b0);
    rdata = readdata_i;
    read_o <= 1'b0;
    write_o <= 1'b0;
    address_o <= ~address_o;
    writedata_o <= ~writedata_o;
  endtask
endmodule

`default_nettype wire

// [verification/phy_diag_sva.sv]
`timescale 1ns/1ns
`default_nettype none

module phy_diag_sva #(
  parameter int unsigned BLINK_CYCLES = phy_diag_pkg::BLINK_CYCLES
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // register bus
  input wire logic [11:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // status and lanes
  input wire logic link_up_i,
  input wire logic speed100_i,
  input wire logic full_duplex_i,
  input wire logic partner_swap_i,
  input wire phy_diag_pkg::dibit_s line_rx_i,
  input wire phy_diag_pkg::dibit_s line_tx_o,
  // watched outputs
  input wire logic indicator_out_a_n_o,
  input wire logic indicator_out_b_n_o,
  input wire logic irq_out_o,
  input wire logic mdix_swap_o,
  input wire logic tdr_start_o
);
  logic wr_ok;
  logic start_wr;
  logic c2v_q;
  logic [15:0] c2_q;
  logic [7:0] ien_q;
  assign wr_ok = avs_write_i && !avs_waitrequest_o;
  assign start_wr = wr_ok && avs_address_i == {phy_diag_pkg::IDX_CABLE, 2'b00}
                    && avs_writedata_i[15];

  // ----------------------------------------
  // shadow of control-2 and interrupt enables
  // ----------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      c2v_q <= 1'b0;
      c2_q <= 16'h0000;
      ien_q <= 8'h00;
    end else begin
      if (wr_ok && avs_address_i == {phy_diag_pkg::IDX_CTRL2, 2'b00}) begin
        c2v_q <= 1'b1;
        c2_q <= avs_writedata_i[15:0];
      end
      if (wr_ok && avs_address_i == {phy_diag_pkg::IDX_INT, 2'b00}) begin
        ien_q <= avs_writedata_i[15:8];
      end
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_req;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_ans;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  property p_ack;
    s_req |=> s_ans;
  endproperty
  property p_upper;
    !avs_waitrequest_o |-> avs_readdata_o[31:16] == 16'h0000;
  endproperty
  property p_swap;
    $past(c2v_q) |-> mdix_swap_o == ($past(c2_q[13]) ? $past(partner_swap_i) : $past(c2_q[14]));
  endproperty
  property p_remote;
    $past(c2v_q && c2_q[2] && link_up_i && speed100_i && full_duplex_i)
      |-> line_tx_o == $past(line_rx_i);
  endproperty
  property p_speed;
    $past(c2v_q && c2_q[5:4] != 2'b01) |-> indicator_out_b_n_o == !$past(link_up_i && speed100_i);
  endproperty
  property p_link;
    $past(c2v_q && c2_q[5:4] == 2'b01) |-> indicator_out_a_n_o == !$past(link_up_i);
  endproperty
  property p_irq_off;
    $past(c2v_q && ien_q == 8'h00) |-> irq_out_o == !$past(c2_q[9]);
  endproperty
  property p_start;
    tdr_start_o |-> $past(start_wr) ##1 !tdr_start_o;
  endproperty

  a_ack: assert property (p_ack) else $error("bus answer not a single cycle");
  a_upper: assert property (p_upper) else $error("read data upper half not zero");
  a_swap: assert property (p_swap) else $error("pair swap wrong");
  a_remote: assert property (p_remote) else $error("remote loop data wrong");
  a_speed: assert property (p_speed) else $error("speed indicator wrong");
  a_link: assert property (p_link) else $error("link indicator wrong");
  a_irq_off: assert property (p_irq_off) else $error("interrupt active while masked");
  a_start: assert property (p_start) else $error("cable start pulse wrong");
endmodule

bind phy_status_diag_control phy_diag_sva #(.BLINK_CYCLES(BLINK_CYCLES)) u_sva (
  .mclk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
  .avs_readdata_o, .avs_waitrequest_o, .link_up_i, .speed100_i, .full_duplex_i,
  .partner_swap_i, .line_rx_i, .line_tx_o, .indicator_out_a_n_o, .indicator_out_b_n_o,
  .irq_out_o, .mdix_swap_o, .tdr_start_o
);

`default_nettype wire

// [verification/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  logic mclk_i, rst_n_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [11:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rv;
  logic [3:0] avs_byteenable_i, tdr_amp_o;
  logic [2:0] cfg_strap_i, tdr_result_i;
  logic link_up_i, speed100_i, full_duplex_i, activity_i, partner_swap_i, tdr_done_i;
  logic [7:0] irq_event_i;
  logic [6:0] quality_raw_i;
  logic indicator_out_a_n_o, indicator_out_b_n_o, irq_out_o, mdix_swap_o, tdr_start_o;
  logic tdr_large_o;
  phy_diag_pkg::dibit_s rmii_tx_i, core_rx_i, line_rx_i, rmii_rx_o, line_tx_o;
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int n;
  int starts = 0;

  phy_status_diag_control #(.BLINK_CYCLES(8)) dut (.mclk_i, .rst_n_i, .avs_address_i,
    .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
    .avs_waitrequest_o, .cfg_strap_i, .link_up_i, .speed100_i, .full_duplex_i, .activity_i,
    .partner_swap_i, .irq_event_i, .quality_raw_i, .tdr_done_i, .tdr_result_i, .rmii_tx_i,
    .core_rx_i, .line_rx_i, .rmii_rx_o, .line_tx_o, .indicator_out_a_n_o,
    .indicator_out_b_n_o, .irq_out_o, .mdix_swap_o, .tdr_start_o, .tdr_large_o, .tdr_amp_o);
  mgmt_master mac (.mclk_i, .address_o(avs_address_i), .read_o(avs_read_i),
    .write_o(avs_write_i), .writedata_o(avs_writedata_i), .byteenable_o(avs_byteenable_i),
    .readdata_i(avs_readdata_o), .waitrequest_i(avs_waitrequest_o));

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge mclk_i) begin
    cyc++;
    if (tdr_start_o === 1'b1) begin
      starts++;
    end
    if (cyc == 6000) begin
      num_errors++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic idle(input int k);
    repeat (k) @(posedge mclk_i);
  endtask

  task automatic wr(input logic [9:0] idx, input logic [15:0] d);
    mac.xfer(1'b1, idx, d, rv);
  endtask

  task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
    mac.xfer(1'b0, idx, 16'h0000, rv);
    chk(rv, exp);
  endtask

  task automatic do_reset(input logic [2:0] s);
    rst_n_i <= 1'b0;
    cfg_strap_i <= s;
    idle(10);
    rst_n_i <= 1'b1;
    idle(5);
  endtask

  task automatic pulse_irq(input logic [7:0] e);
    irq_event_i <= e;
    @(posedge mclk_i);
    irq_event_i <= 8'h00;
    idle(3);
  endtask

  task automatic count_blink(input logic use_b, output int cnt);
    logic p;
    activity_i <= 1'b1;
    @(posedge mclk_i);
    activity_i <= 1'b0;
    cnt = 0;
    p = use_b ? indicator_out_b_n_o : indicator_out_a_n_o;
    repeat (40) begin
      @(posedge mclk_i);
      if ((use_b ? indicator_out_b_n_o : indicator_out_a_n_o) !== p) cnt++;
      p = use_b ? indicator_out_b_n_o : indicator_out_a_n_o;
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_n_i = 1'b0;
    cfg_strap_i = 3'h2;
    {link_up_i, speed100_i, full_duplex_i, activity_i, partner_swap_i, tdr_done_i} = 6'h00;
    irq_event_i = 8'h00;
    quality_raw_i = 7'h00;
    tdr_result_i = 3'h0;
    rmii_tx_i = 3'h0;
    core_rx_i = 3'h0;
    line_rx_i = 3'h0;
    @(posedge mclk_i);
    do_reset(3'h2);
    rd(phy_diag_pkg::IDX_BASIC, 32'h0000_3100);
    rd(phy_diag_pkg::IDX_CTRL2, 32'h0000_0000);
    rd(phy_diag_pkg::IDX_AMP, 32'h0000_0020);
    rd(phy_diag_pkg::IDX_INT, 32'h0000_0000);
    wr(10'h3FF, 16'hFFFF);
    rd(10'h3FF, 32'h0000_0000);
    $display("registers done");
    partner_swap_i <= 1'b1;
    wr(phy_diag_pkg::IDX_CTRL2, 16'h0000);
    idle(3);
    chk(32'(mdix_swap_o), 32'h0);
    wr(phy_diag_pkg::IDX_CTRL2, 16'h4000);
    idle(3);
    chk(32'(mdix_swap_o), 32'h1);
    wr(phy_diag_pkg::IDX_CTRL2, 16'h2000);
    idle(3);
    chk(32'(mdix_swap_o), 32'h1);
    partner_swap_i <= 1'b0;
    idle(3);
    chk(32'(mdix_swap_o), 32'h0);
    $display("crossover done");
    link_up_i <= 1'b1;
    speed100_i <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      wr(phy_diag_pkg::IDX_CTRL2, m ? 16'h0010 : 16'h0000);
      idle(3);
      chk(32'({indicator_out_a_n_o, indicator_out_b_n_o}), m ? 32'h1 : 32'h0);
      count_blink(m[0], n);
      chk(32'(n), 32'h2);
      idle(40);
      chk(32'({indicator_out_a_n_o, indicator_out_b_n_o}), m ? 32'h1 : 32'h0);
    end
    link_up_i <= 1'b0;
    idle(3);
    chk(32'({indicator_out_a_n_o, indicator_out_b_n_o}), 32'h3);
    wr(phy_diag_pkg::IDX_CTRL2, 16'h0000);
    link_up_i <= 1'b1;
    speed100_i <= 1'b0;
    idle(3);
    chk(32'({indicator_out_a_n_o, indicator_out_b_n_o}), 32'h1);
    $display("indicators done");
    wr(phy_diag_pkg::IDX_INT, 16'h0100);
    pulse_irq(8'h01);
    chk(32'(irq_out_o), 32'h0);
    rd(phy_diag_pkg::IDX_INT, 32'h0000_0101);
    idle(3);
    chk(32'(irq_out_o), 32'h1);
    rd(phy_diag_pkg::IDX_INT, 32'h0000_0100);
    pulse_irq(8'h80);
    chk(32'(irq_out_o), 32'h1);
    rd(phy_diag_pkg::IDX_INT, 32'h0000_0180);
    wr(phy_diag_pkg::IDX_CTRL2, 16'h0200);
    idle(3);
    chk(32'(irq_out_o), 32'h0);
    pulse_irq(8'h01);
    chk(32'(irq_out_o), 32'h1);
    rd(phy_diag_pkg::IDX_INT, 32'h0000_0101);
    $display("interrupt done");
    wr(phy_diag_pkg::IDX_BASIC, 16'h4100);
    wr(phy_diag_pkg::IDX_CTRL1C, 16'h0020);
    rmii_tx_i <= 3'b110;
    core_rx_i <= 3'b101;
    line_rx_i <= 3'b111;
    idle(3);
    chk({29'h0, rmii_rx_o}, 32'h6);
    chk({29'h0, line_tx_o}, 32'h0);
    wr(phy_diag_pkg::IDX_CTRL1C, 16'h0000);
    idle(3);
    chk({29'h0, rmii_rx_o}, 32'h5);
    speed100_i <= 1'b1;
    full_duplex_i <= 1'b1;
    wr(phy_diag_pkg::IDX_CTRL2, 16'h0004);
    idle(3);
    chk({29'h0, line_tx_o}, 32'h7);
    speed100_i <= 1'b0;
    idle(3);
    chk({29'h0, line_tx_o}, 32'h6);
    $display("loopback done");
    do_reset(3'h0);
    rd(phy_diag_pkg::IDX_CTRL2, 32'h0000_2000);
    wr(phy_diag_pkg::IDX_CABLE, 16'h8000);
    rd(phy_diag_pkg::IDX_CABLE, 32'h0000_0000);
    chk(32'(starts), 32'h0);
    wr(phy_diag_pkg::IDX_CTRL2, 16'h4000);
    for (int i = 0; i < 2; i++) begin
      wr(phy_diag_pkg::IDX_AMP, i ? 16'h0070 : 16'h0020);
      wr(phy_diag_pkg::IDX_PULSE_SEL, i ? 16'h8000 : 16'h0000);
      wr(phy_diag_pkg::IDX_CABLE, 16'h8000);
      mac.xfer(1'b0, phy_diag_pkg::IDX_CABLE, 16'h0000, rv);
      chk(32'(rv[15]), 32'h1);
      chk({27'h0, tdr_large_o, tdr_amp_o}, i ? 32'h17 : 32'h2);
      tdr_result_i <= 3'h5 - 3'(i);
      tdr_done_i <= 1'b1;
      @(posedge mclk_i);
      tdr_done_i <= 1'b0;
      idle(2);
      rd(phy_diag_pkg::IDX_CABLE, {17'h0, 3'h5 - 3'(i), 12'h000});
    end
    chk(32'(starts), 32'h2);
    $display("cable test done");
    for (int i = 0; i < 2; i++) begin
      quality_raw_i <= i ? 7'h05 : 7'h2A;
      idle(210);
      rd(phy_diag_pkg::IDX_QUALITY, i ? 32'h0000_0500 : 32'h0000_2A00);
    end
    $display("quality done");
    complete_run();
  end
endmodule

`default_nettype wire
